// [include/tsa_pkg.sv]
/*
 * Shared constants and carrier types for the temperature status and
 * alert logic: register pointers, status bit positions, widths, resets.
 * Assumes temperatures arrive as 12-bit codes with 4 fractional bits.
 */
package tsa_pkg;

	// Register pointer values
	localparam logic [7:0] TSA_PTR_LOC_HI = 8'h00;
	localparam logic [7:0] TSA_PTR_REM_HI = 8'h01;
	localparam logic [7:0] TSA_PTR_STATUS = 8'h02;
	localparam logic [7:0] TSA_PTR_REM_LO = 8'h10;
	localparam logic [7:0] TSA_PTR_LOC_LO = 8'h15;

	// Status byte bit positions
	localparam int TSA_ST_BUSY = 7;
	localparam int TSA_ST_LOVER = 6;
	localparam int TSA_ST_LUNDER = 5;
	localparam int TSA_ST_ROVER = 4;
	localparam int TSA_ST_RUNDER = 3;
	localparam int TSA_ST_OPEN = 2;
	localparam int TSA_ST_RCRIT = 1;
	localparam int TSA_ST_LCRIT = 0;

	// Widths and reset values
	localparam int TSA_TEMP_W = 12;
	localparam int TSA_FRAC_W = 4;
	localparam logic [7:0] TSA_RESULT_RST = 8'h00;
	localparam logic [3:0] TSA_FRAC_ZERO = 4'h0;
	localparam logic [7:0] TSA_BYTE_ZERO = 8'h00;
	localparam logic [7:0] TSA_ARA_DATA_DEF = 8'h5a;

	// One conversion result from the converter
	typedef struct packed {
		logic [TSA_TEMP_W-1:0] loc;
		logic [TSA_TEMP_W-1:0] rem;
		logic open_diode;
	} tsa_conv_t;

	// Limits of one channel, 1 degree per LSB
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic [7:0] crit;
	} tsa_lim_t;

	// Comparator verdicts of one channel
	typedef struct packed {
		logic over;
		logic over_ok;
		logic under;
		logic crit_trip;
		logic crit_ok;
	} tsa_chk_t;

	// Read request held stable across the clock crossing
	typedef struct packed {
		logic [7:0] ptr;
		logic ara;
	} tsa_lreq_t;

endpackage : tsa_pkg

// [src/tsa_chan_check.sv]
/*
 * Limit comparators for one temperature channel.
 * Purely combinational; the caller samples the verdicts at the end of
 * a conversion. Assumes unsigned codes and limits in whole degrees.
 */
`timescale 1ns/1ps
`default_nettype none

module tsa_chan_check
	import tsa_pkg::*;
(
	input wire logic [TSA_TEMP_W-1:0] temp,
	input wire tsa_pkg::tsa_lim_t lim,
	input wire logic [7:0] hyst,
	output tsa_pkg::tsa_chk_t chk
);

	// Limit minus hysteresis, floored at zero to avoid wrap
	function automatic logic [7:0] tsa_minus_hyst(
		input logic [7:0] limit,
		input logic [7:0] h
	);
		tsa_minus_hyst = (limit > h) ? 8'(limit - h) : TSA_BYTE_ZERO;
	endfunction : tsa_minus_hyst

	// Whole-degree limit widened to the result's fixed-point form
	function automatic logic [TSA_TEMP_W-1:0] tsa_widen(
		input logic [7:0] limit
	);
		tsa_widen = {limit, TSA_FRAC_ZERO};
	endfunction : tsa_widen

	// Compare against high, low and critical limits
	always_comb
	begin
		chk.over = temp > tsa_widen(lim.high);
		chk.under = temp < tsa_widen(lim.low);
		chk.crit_trip = temp > tsa_widen(lim.crit);
		chk.crit_ok = temp <= tsa_widen(tsa_minus_hyst(lim.crit, hyst));
		chk.over_ok = temp <= tsa_widen(tsa_minus_hyst(lim.high, hyst));
	end

endmodule : tsa_chan_check

`default_nettype wire

// [src/tsa_link_port.sv]
/*
 * Link-clock side of the register read path. Captures a read request,
 * hands it to the core clock by toggle, and returns the byte when the
 * core's acknowledge toggle arrives. Assumes one request at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module tsa_link_port
	import tsa_pkg::*;
(
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic lk_rd_req,
	input wire logic lk_ara_req,
	input wire logic [7:0] lk_ptr,
	input wire logic ack_tgl,
	input wire logic [7:0] core_data,
	output tsa_pkg::tsa_lreq_t req_q,
	output logic req_tgl_q,
	output logic [7:0] lk_rd_data,
	output logic lk_rd_done,
	output logic lk_busy
);

	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_s3_q;
	logic ack_seen;

	// Two-stage synchroniser for the core acknowledge, third for edges
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end
		else
		begin
			ack_s1_q <= ack_tgl;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
		end
	end

	assign ack_seen = ack_s2_q ^ ack_s3_q;

	// Request capture; ignored while a read is outstanding
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			req_q <= '0;
			req_tgl_q <= 1'b0;
			lk_busy <= 1'b0;
		end
		else if (!lk_busy && (lk_rd_req || lk_ara_req))
		begin
			req_q.ptr <= lk_ptr;
			req_q.ara <= lk_ara_req;
			req_tgl_q <= ~req_tgl_q;
			lk_busy <= 1'b1;
		end
		else if (ack_seen)
			lk_busy <= 1'b0;
	end

	// Core data is held stable until the next request, safe to take
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			lk_rd_data <= TSA_BYTE_ZERO;
			lk_rd_done <= 1'b0;
		end
		else
		begin
			lk_rd_done <= ack_seen;
			if (ack_seen)
				lk_rd_data <= core_data;
		end
	end

endmodule : tsa_link_port

`default_nettype wire

// [src/tsa_status_alert.sv]
/*
 * Result, status, alert and critical-output logic of a two-channel
 * temperature monitor. Host reads arrive on the link clock and cross
 * by toggle handshake; converter results arrive on clk.
 * Assumes converter inputs and configuration are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tsa_status_alert
	import tsa_pkg::*;
#(
	parameter logic [7:0] ARA_DATA = TSA_ARA_DATA_DEF // arbitrary value
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic lk_rd_req,
	input wire logic lk_ara_req,
	input wire logic [7:0] lk_ptr,
	output logic [7:0] lk_rd_data,
	output logic lk_rd_done,
	output logic lk_busy,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire tsa_pkg::tsa_conv_t conv,
	input wire tsa_pkg::tsa_lim_t loc_lim,
	input wire tsa_pkg::tsa_lim_t rem_lim,
	input wire logic [7:0] critical_overtemp_output_hyst,
	input wire logic shared_pin_function_select,
	input wire logic alert_output_disable,
	output logic shared_pin_n_q,
	output logic critical_overtemp_output_n_q
);

	tsa_lreq_t req;
	logic req_tgl;
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic ack_tgl_q;
	logic [7:0] rd_data_q;
	logic [7:0] rd_mux;
	logic access;
	logic rd_status;
	logic rd_rem_hi;
	logic rd_rem_lo;
	logic rd_other;
	logic rd_ara;
	logic lock_lo_q;
	logic lock_hi_q;
	logic [7:0] loc_hi_q;
	logic [3:0] loc_lo_q;
	logic [7:0] rem_hi_q;
	logic [3:0] rem_lo_q;
	tsa_chk_t loc_chk;
	tsa_chk_t rem_chk;
	logic second_mode;
	logic [6:2] cond_new;
	logic [6:2] cond_q;
	logic [6:0] flag_d;
	logic [6:0] flag_q;
	logic irq_d;
	logic irq_q;

	assign second_mode = shared_pin_function_select;

	// Link-clock side of the read path
	tsa_link_port u_link (
		.link_clk(link_clk),
		.link_rst(link_rst),
		.lk_rd_req(lk_rd_req),
		.lk_ara_req(lk_ara_req),
		.lk_ptr(lk_ptr),
		.ack_tgl(ack_tgl_q),
		.core_data(rd_data_q),
		.req_q(req),
		.req_tgl_q(req_tgl),
		.lk_rd_data(lk_rd_data),
		.lk_rd_done(lk_rd_done),
		.lk_busy(lk_busy)
	);

	// Channel comparators
	tsa_chan_check u_loc (
		.temp(conv.loc),
		.lim(loc_lim),
		.hyst(critical_overtemp_output_hyst),
		.chk(loc_chk)
	);

	tsa_chan_check u_rem (
		.temp(conv.rem),
		.lim(rem_lim),
		.hyst(critical_overtemp_output_hyst),
		.chk(rem_chk)
	);

	// Request toggle synchroniser; stage three only feeds edge detect
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end
		else
		begin
			req_s1_q <= req_tgl;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// Decoded read events; req is stable once the toggle has crossed
	always_comb
	begin
		access = req_s2_q ^ req_s3_q;
		rd_ara = access && req.ara;
		rd_status = access && !req.ara && (req.ptr == TSA_PTR_STATUS);
		rd_rem_hi = access && !req.ara && (req.ptr == TSA_PTR_REM_HI);
		rd_rem_lo = access && !req.ara && (req.ptr == TSA_PTR_REM_LO);
		rd_other = access && !req.ara && !rd_rem_hi && !rd_rem_lo;
	end

	// Read data selection; unknown pointers read zero
	always_comb
	begin
		rd_mux = TSA_BYTE_ZERO;
		if (req.ara)
			rd_mux = ARA_DATA;
		else
		begin
			case (req.ptr)
				TSA_PTR_LOC_HI: rd_mux = loc_hi_q;
				TSA_PTR_REM_HI: rd_mux = rem_hi_q;
				TSA_PTR_STATUS: rd_mux = {conv_busy, flag_q};
				TSA_PTR_REM_LO: rd_mux = {rem_lo_q, TSA_FRAC_ZERO};
				TSA_PTR_LOC_LO: rd_mux = {loc_lo_q, TSA_FRAC_ZERO};
				default: rd_mux = TSA_BYTE_ZERO;
			endcase
		end
	end

	// Capture answer, then acknowledge back to the link side
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rd_data_q <= TSA_BYTE_ZERO;
			ack_tgl_q <= 1'b0;
		end
		else if (access)
		begin
			rd_data_q <= rd_mux;
			ack_tgl_q <= ~ack_tgl_q;
		end
	end

	// Remote byte-pair lock; the first remote byte read freezes its partner
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lock_lo_q <= 1'b0;
			lock_hi_q <= 1'b0;
		end
		else if (rd_rem_hi)
		begin
			lock_lo_q <= !lock_hi_q;
			lock_hi_q <= 1'b0;
		end
		else if (rd_rem_lo)
		begin
			lock_hi_q <= !lock_lo_q;
			lock_lo_q <= 1'b0;
		end
		else if (rd_other)
		begin
			lock_lo_q <= 1'b0;
			lock_hi_q <= 1'b0;
		end
	end

	// Result registers, refreshed at conversion end unless locked
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			loc_hi_q <= TSA_RESULT_RST;
			loc_lo_q <= TSA_FRAC_ZERO;
			rem_hi_q <= TSA_RESULT_RST;
			rem_lo_q <= TSA_FRAC_ZERO;
		end
		else if (conv_done)
		begin
			loc_hi_q <= conv.loc[TSA_TEMP_W-1:TSA_FRAC_W];
			loc_lo_q <= conv.loc[TSA_FRAC_W-1:0];
			if (!lock_hi_q)
				rem_hi_q <= conv.rem[TSA_TEMP_W-1:TSA_FRAC_W];
			if (!lock_lo_q)
				rem_lo_q <= conv.rem[TSA_FRAC_W-1:0];
		end
	end

	// Causing conditions seen by the newest conversion
	always_comb
	begin
		cond_new[TSA_ST_LOVER] = loc_chk.over;
		cond_new[TSA_ST_LUNDER] = loc_chk.under;
		cond_new[TSA_ST_ROVER] = rem_chk.over;
		cond_new[TSA_ST_RUNDER] = rem_chk.under;
		cond_new[TSA_ST_OPEN] = conv.open_diode;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cond_q <= '0;
		else if (conv_done)
			cond_q <= cond_new;
	end

	// Flag next state; a set in the clearing cycle wins over the clear
	always_comb
	begin
		flag_d = flag_q;
		// Status read clears only flags whose cause has gone; in second mode only the open-diode flag
		if (rd_status)
		begin
			for (int i = TSA_ST_OPEN; i <= TSA_ST_LOVER; i++)
			begin
				if (!cond_q[i] && (!second_mode || i == TSA_ST_OPEN))
					flag_d[i] = 1'b0;
			end
		end
		if (conv_done)
		begin
			if (second_mode)
			begin
				// Over flags follow the critical-style hysteresis
				if (loc_chk.over)
					flag_d[TSA_ST_LOVER] = 1'b1;
				else if (loc_chk.over_ok)
					flag_d[TSA_ST_LOVER] = 1'b0;
				if (rem_chk.over)
					flag_d[TSA_ST_ROVER] = 1'b1;
				else if (rem_chk.over_ok)
					flag_d[TSA_ST_ROVER] = 1'b0;
				// Under flags are not sticky in this mode
				flag_d[TSA_ST_LUNDER] = loc_chk.under;
				flag_d[TSA_ST_RUNDER] = rem_chk.under;
				if (conv.open_diode)
					flag_d[TSA_ST_OPEN] = 1'b1;
			end
			else
			begin
				for (int i = TSA_ST_OPEN; i <= TSA_ST_LOVER; i++)
				begin
					if (cond_new[i])
						flag_d[i] = 1'b1;
				end
			end
			// Critical flags self-clear at or below limit minus hysteresis
			if (rem_chk.crit_trip)
				flag_d[TSA_ST_RCRIT] = 1'b1;
			else if (rem_chk.crit_ok)
				flag_d[TSA_ST_RCRIT] = 1'b0;
			if (loc_chk.crit_trip)
				flag_d[TSA_ST_LCRIT] = 1'b1;
			else if (loc_chk.crit_ok)
				flag_d[TSA_ST_LCRIT] = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flag_q <= '0;
		else
			flag_q <= flag_d;
	end

	// Interrupt latch; status reads do not touch it
	always_comb
	begin
		irq_d = irq_q;
		if (rd_ara && flag_q[6:2] == '0 && cond_q == '0)
			irq_d = 1'b0;
		if (!second_mode && flag_d[6:2] != '0)
			irq_d = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	// Pin drivers; both active low and high from reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			shared_pin_n_q <= 1'b1;
			critical_overtemp_output_n_q <= 1'b1;
		end
		else
		begin
			critical_overtemp_output_n_q <=
				!(flag_d[TSA_ST_RCRIT] || flag_d[TSA_ST_LCRIT]);
			if (second_mode)
				shared_pin_n_q <=
					!(flag_d[TSA_ST_LOVER] || flag_d[TSA_ST_ROVER]);
			else
				shared_pin_n_q <= !(irq_d && !alert_output_disable);
		end
	end

endmodule : tsa_status_alert

`default_nettype wire

// [dv/tsa_status_alert_monitor.sv]
/* Port checker for the status and alert block.
   Bound into every instance; watches core and link clock domains. */
`timescale 1ns/1ps
`default_nettype none
module tsa_monitor
	import tsa_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic lk_rd_req,
	input wire logic lk_busy,
	input wire logic lk_rd_done,
	input wire logic [7:0] lk_rd_data,
	input wire logic conv_done,
	input wire tsa_pkg::tsa_conv_t conv,
	input wire tsa_pkg::tsa_lim_t loc_lim,
	input wire tsa_pkg::tsa_lim_t rem_lim,
	input wire logic [7:0] critical_overtemp_output_hyst,
	input wire logic shared_pin_function_select,
	input wire logic alert_output_disable,
	input wire logic shared_pin_n_q,
	input wire logic critical_overtemp_output_n_q
);
	// Conversion above either critical limit
	sequence s_crit;
		conv_done && (conv.rem > {rem_lim.crit, 4'h0}
		|| conv.loc > {loc_lim.crit, 4'h0});
	endsequence
	// Both channels at or below limit minus hysteresis, no underflow
	sequence s_cool;
		conv_done && rem_lim.crit >= critical_overtemp_output_hyst && loc_lim.crit >= critical_overtemp_output_hyst
		&& conv.rem <= {rem_lim.crit - critical_overtemp_output_hyst, 4'h0}
		&& conv.loc <= {loc_lim.crit - critical_overtemp_output_hyst, 4'h0};
	endsequence
	// Remote over its high limit
	sequence s_rhot;
		conv_done && conv.rem > {rem_lim.high, 4'h0};
	endsequence
	// Alert mode with the mask held for two edges
	sequence s_masked;
		(!shared_pin_function_select && alert_output_disable)[*2];
	endsequence

	a_crit_trip: assert property (@(posedge clk) disable iff (sys_rst)
		s_crit |-> ##[1:2] !critical_overtemp_output_n_q)
		else $error("critical pin not low after trip");
	a_crit_free: assert property (@(posedge clk) disable iff (sys_rst)
		s_cool |-> ##[1:2] critical_overtemp_output_n_q)
		else $error("critical pin not released");
	a_crit_only_conv: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(critical_overtemp_output_n_q)
		|-> $past(conv_done) || $past(conv_done, 2))
		else $error("critical pin moved without conversion");
	a_alert_trip: assert property (@(posedge clk) disable iff (sys_rst)
		!shared_pin_function_select && !alert_output_disable ##0 s_rhot
		|-> ##[1:2] !shared_pin_n_q)
		else $error("alert pin not low on over limit");
	a_alert_mask: assert property (@(posedge clk) disable iff (sys_rst)
		s_masked |-> shared_pin_n_q)
		else $error("masked alert pin driven low");
	a_second_trip: assert property (@(posedge clk) disable iff (sys_rst)
		shared_pin_function_select ##0 s_rhot |-> ##[1:2] !shared_pin_n_q)
		else $error("second mode pin not low");
	a_done_pulse: assert property (@(posedge link_clk) disable iff (link_rst)
		lk_rd_done |=> !lk_rd_done)
		else $error("read done longer than one cycle");
	a_req_taken: assert property (@(posedge link_clk) disable iff (link_rst)
		lk_rd_req && !lk_busy |=> lk_busy)
		else $error("read request not taken");
	a_read_bound: assert property (@(posedge link_clk) disable iff (link_rst)
		$rose(lk_busy) |-> ##[1:12] lk_rd_done)
		else $error("read never answered");
	a_busy_ends: assert property (@(posedge link_clk) disable iff (link_rst)
		lk_rd_done |=> !lk_busy)
		else $error("busy stays after done");
	a_data_held: assert property (@(posedge link_clk) disable iff (link_rst)
		!lk_rd_done |-> $stable(lk_rd_data))
		else $error("read data moved without done");
endmodule : tsa_monitor

bind tsa_status_alert tsa_monitor i_mon (.clk, .sys_rst, .link_clk,
	.link_rst, .lk_rd_req, .lk_busy, .lk_rd_done, .lk_rd_data, .conv_done,
	.conv, .loc_lim, .rem_lim, .critical_overtemp_output_hyst, .shared_pin_function_select,
	.alert_output_disable, .shared_pin_n_q, .critical_overtemp_output_n_q);
`default_nettype wire

// [dv/tsa_host_model.sv]
/* Serial bus host seen at the link port: one read at a time.
   The bench calls task rd; all timing follows link_clk. */
`timescale 1ns/1ps
`default_nettype none
module tsa_host_model (
	input wire logic link_clk,
	input wire logic lk_rd_done,
	input wire logic [7:0] lk_rd_data,
	output logic lk_rd_req,
	output logic lk_ara_req,
	output logic [7:0] lk_ptr
);
	// Idle lines before the first read
	initial
	begin
		lk_rd_req = 1'b0;
		lk_ara_req = 1'b0;
		lk_ptr = 8'hff;
	end
	// Register or address read; ok stays low if no answer
	task automatic rd(input logic [7:0] p, input logic a,
		output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge link_clk);
		#1;
		lk_rd_req = !a;
		lk_ara_req = a;
		lk_ptr = p;
		@(posedge link_clk);
		#1;
		lk_rd_req = 1'b0;
		lk_ara_req = 1'b0;
		lk_ptr = ~p; // Released pointer shows a changing pattern
		for (int i = 0; i < 20 && !ok; i++)
		begin
			@(posedge link_clk);
			#1;
			if (lk_rd_done === 1'b1)
			begin
				d = lk_rd_data;
				ok = 1'b1;
			end
		end
	endtask : rd
endmodule : tsa_host_model
`default_nettype wire

// [dv/tb.sv]
/* Self-checking bench for tsa_status_alert.
   Host model reads over the link; bench feeds converter results. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tsa_pkg::*;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_rst = 1'b1;
	logic conv_busy = 1'b0;
	logic conv_done = 1'b0;
	logic sel = 1'b0;
	logic dis = 1'b0;
	tsa_conv_t conv = '0;
	tsa_lim_t lim = '{8'h40, 8'h10, 8'h50};
	logic [7:0] hyst = 8'h05;
	logic lk_rd_req, lk_ara_req, lk_rd_done, lk_busy, pin_n, crit_n;
	logic [7:0] lk_ptr, lk_rd_data;
	int bad_count = 0;
	int n_compared = 0;

	// Clocks; link period keeps edges off the core grid
	always #5 clk = ~clk;
	always #62.5 link_clk = ~link_clk;

	tsa_status_alert i_dut (.clk(clk), .sys_rst(sys_rst),
		.link_clk(link_clk), .link_rst(link_rst), .lk_rd_req(lk_rd_req),
		.lk_ara_req(lk_ara_req), .lk_ptr(lk_ptr), .lk_rd_data(lk_rd_data),
		.lk_rd_done(lk_rd_done), .lk_busy(lk_busy), .conv_busy(conv_busy),
		.conv_done(conv_done), .conv(conv), .loc_lim(lim), .rem_lim(lim),
		.critical_overtemp_output_hyst(hyst), .shared_pin_function_select(sel),
		.alert_output_disable(dis), .shared_pin_n_q(pin_n),
		.critical_overtemp_output_n_q(crit_n));

	tsa_host_model i_host (.link_clk(link_clk), .lk_rd_done(lk_rd_done),
		.lk_rd_data(lk_rd_data), .lk_rd_req(lk_rd_req),
		.lk_ara_req(lk_ara_req), .lk_ptr(lk_ptr));

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk

	// Read and compare; an address read only needs an answer
	task automatic rdc(input logic [7:0] p, input logic a,
		input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		i_host.rd(p, a, d, ok);
		if (ok !== 1'b1)
		begin
			bad_count++;
			end_of_test();
		end
		if (!a)
			chk(d, e);
	endtask : rdc

	// One conversion, then time for the pins to follow
	task automatic cv(input logic [11:0] l, input logic [11:0] r,
		input logic o);
		@(posedge clk);
		#1;
		conv_done = 1'b1;
		conv = '{l, r, o};
		@(posedge clk);
		#1;
		conv_done = 1'b0;
		repeat (3) @(posedge clk);
	endtask : cv

	task automatic pins(input logic a, input logic c);
		repeat (3) @(posedge clk);
		#1;
		chk({6'h00, pin_n, crit_n}, {6'h00, a, c});
	endtask : pins

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		repeat (3) @(posedge link_clk);
		#1;
		link_rst = 1'b0;
		pins(1'b1, 1'b1);
		rdc(TSA_PTR_REM_HI, 1'b0, 8'h00);
		cv(12'h200, 12'h2a5, 1'b0);
		rdc(TSA_PTR_REM_HI, 1'b0, 8'h2a);
		cv(12'h200, 12'h303, 1'b0);
		rdc(TSA_PTR_REM_LO, 1'b0, 8'h00);
		rdc(TSA_PTR_LOC_HI, 1'b0, 8'h20);
		cv(12'h200, 12'h347, 1'b0);
		rdc(TSA_PTR_REM_LO, 1'b0, 8'h70);
		cv(12'h200, 12'h3b1, 1'b0);
		rdc(TSA_PTR_REM_HI, 1'b0, 8'h34);
		rdc(TSA_PTR_LOC_HI, 1'b0, 8'h20);
		cv(12'h200, 12'h2d9, 1'b0);
		rdc(TSA_PTR_REM_HI, 1'b0, 8'h2d);
		rdc(TSA_PTR_LOC_HI, 1'b0, 8'h20);
		cv(12'h200, 12'h2e6, 1'b0);
		rdc(TSA_PTR_REM_LO, 1'b0, 8'h60);
		cv(12'h0f0, 12'h510, 1'b1);
		pins(1'b0, 1'b0);
		conv_busy = 1'b1;
		rdc(TSA_PTR_STATUS, 1'b0, 8'hb6);
		conv_busy = 1'b0;
		rdc(8'h00, 1'b1, 8'h00);
		pins(1'b0, 1'b0);
		cv(12'h200, 12'h4c0, 1'b0);
		pins(1'b0, 1'b0);
		rdc(TSA_PTR_STATUS, 1'b0, 8'h36);
		cv(12'h200, 12'h4b0, 1'b0);
		pins(1'b0, 1'b1);
		rdc(TSA_PTR_STATUS, 1'b0, 8'h10);
		cv(12'h200, 12'h2a0, 1'b0);
		rdc(TSA_PTR_STATUS, 1'b0, 8'h10);
		rdc(TSA_PTR_STATUS, 1'b0, 8'h00);
		pins(1'b0, 1'b1);
		rdc(8'h00, 1'b1, 8'h00);
		pins(1'b1, 1'b1);
		dis = 1'b1;
		cv(12'h200, 12'h410, 1'b0);
		pins(1'b1, 1'b1);
		rdc(TSA_PTR_STATUS, 1'b0, 8'h10);
		sel = 1'b1;
		cv(12'h0f0, 12'h2a0, 1'b0);
		pins(1'b1, 1'b1);
		cv(12'h200, 12'h410, 1'b0);
		pins(1'b0, 1'b1);
		cv(12'h200, 12'h3c0, 1'b0);
		pins(1'b0, 1'b1);
		cv(12'h200, 12'h3b0, 1'b0);
		pins(1'b1, 1'b1);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
